// ==== src/bridge_clock_run_control_and_retry_alias_regs.sv ====
/*
 * Clock-run control and retry-match aliasing register bank of a two-port
 * bus bridge, reached over AHB-Lite on ref_clk, with the retry matcher and
 * the write-invalidate converter running on the link clock.
 * Assumes one AHB-Lite master issuing single word transfers, link-side
 * request logic clocked by link_clk, and clock-run pins from another domain.
 */
`timescale 1ns/1ps
`include "bridge_clock_run_control_map.svh"

module bridge_clock_run_control_and_retry_alias_regs
	import bridge_clock_run_control_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic hsel,
	input wire logic [7:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic pri_stop_req,
	input wire logic sec_bus_idle,
	input wire logic pri_req_pending,
	output logic sec_clk_stop,
	output logic pri_clk_stop_ok,
	output logic pri_clock_run_control_on,
	output logic sec_clock_run_control_on,
	input wire logic link_clk,
	input wire logic retry_valid,
	input wire logic retry_secondary,
	input wire logic [3:0] retry_cmd,
	input wire logic [3:0] queued_cmd,
	output logic retry_done,
	output logic retry_match,
	input wire logic fwd_valid,
	input wire logic fwd_secondary,
	input wire logic [3:0] fwd_cmd_in,
	output logic fwd_done,
	output logic [3:0] fwd_cmd_out
);

	// ----------------------------------------------------------------------
	// Helper functions
	// ----------------------------------------------------------------------

	// Word decode shared by the read and the write path.
	function automatic logic hits(input logic [7:0] a, input logic [7:0] ofs);
		hits = (a[7:2] == ofs[7:2]);
	endfunction

	// Retry match of a repeated command against the queued one.
	function automatic logic alias_match(
		input logic sec,
		input cmd_t r,
		input cmd_t q,
		input port_opt_t po
	);
		logic rd_al;
		logic wr_al;
		logic lm_al;
		logic lm_r;
		rd_al = sec ? po[`PO_SEC_RD_ALIAS_BIT] : po[`PO_PRI_RD_ALIAS_BIT];
		wr_al = sec ? po[`PO_SEC_WR_ALIAS_BIT] : po[`PO_PRI_WR_ALIAS_BIT];
		lm_al = sec ? po[`PO_SEC_LM_ALIAS_BIT] : po[`PO_PRI_LM_ALIAS_BIT];
		lm_r = (r == mem_read_line_cmd) || (r == mem_read_multiple_cmd);
		alias_match = (r == q)
			|| (rd_al && lm_r && (q == mem_read_cmd))
			|| (wr_al && (r == mem_write_invalidate_cmd) && (q == mem_write_cmd))
			|| (lm_al && (r == mem_read_line_cmd) && (q == mem_read_multiple_cmd))
			|| (lm_al && (r == mem_read_multiple_cmd) && (q == mem_read_line_cmd));
	endfunction

	// Forwarded command after optional write-invalidate conversion.
	function automatic cmd_t forward_cmd(input logic sec, input cmd_t c, input port_opt_t po);
		logic keep;
		keep = sec ? po[`PO_SEC_KEEP_MWI_BIT] : po[`PO_PRI_KEEP_MWI_BIT];
		if ((c == mem_write_invalidate_cmd) && !keep) begin
			forward_cmd = mem_write_cmd;
		end else begin
			forward_cmd = c;
		end
	endfunction

	// ----------------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------------
	logic [31:0] clock_run_control;
	logic [31:0] next_clock_run_control;
	port_opt_t port_option_control;
	port_opt_t next_port_option_control;
	logic dp_write;
	logic [7:0] dp_addr;
	logic ap_take;
	logic [31:0] next_rdata;
	logic [2:0] pin_meta;
	logic [2:0] pin_sync;
	clock_run_control_state_e state;
	clock_run_control_state_e next_state;
	logic stop_cond;
	logic sec_stopped;
	port_opt_t opt_hold;
	logic opt_req;
	logic [1:0] ack_sync;
	logic req_meta;
	logic req_sync;
	logic req_seen;
	port_opt_t link_opt;

	// ----------------------------------------------------------------------
	// AHB-Lite slave
	// ----------------------------------------------------------------------

	// The slave never stalls, so an address phase is taken whenever the bus is ready.
	assign ap_take = hsel && htrans[1] && hready;

	// Remember the address phase of a write for its data phase.
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			dp_write <= 1'b0;
			dp_addr <= 8'h00;
		end else if (hready) begin
			dp_write <= ap_take && hwrite;
			dp_addr <= haddr;
		end
	end

	// Zero wait states and an OKAY answer to every transfer, mapped or not.
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	// Register values after the write now in its data phase; reads use these so
	// a read straight after a write sees the new value.
	always_comb begin
		next_clock_run_control = clock_run_control;
		next_port_option_control = port_option_control;
		if (dp_write && hits(dp_addr, `CLOCK_RUN_CONTROL_OFS)) begin
			next_clock_run_control = hwdata & `CR_WMASK;
		end
		if (dp_write && hits(dp_addr, `PORT_OPTION_CONTROL_OFS)) begin
			next_port_option_control = hwdata[15:0] & `PO_WMASK;
		end
	end

	// Control bits, all writable ones resetting to their documented values.
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			clock_run_control <= `CR_RESET;
			port_option_control <= `PO_RESET;
		end else begin
			clock_run_control <= next_clock_run_control;
			port_option_control <= next_port_option_control;
		end
	end

	// Read mux; unmapped words and reserved bits read as zero.
	always_comb begin
		next_rdata = 32'h0000_0000;
		if (hits(haddr, `CLOCK_RUN_CONTROL_OFS)) begin
			next_rdata = next_clock_run_control;
			next_rdata[`CR_SEC_STOPPED_BIT] = sec_stopped;
		end else if (hits(haddr, `PORT_OPTION_CONTROL_OFS)) begin
			next_rdata = {16'h0000, next_port_option_control};
		end
	end

	// Read data is captured at the address phase and stands through the data phase.
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			hrdata <= 32'h0000_0000;
		end else if (ap_take && !hwrite) begin
			hrdata <= next_rdata;
		end
	end

	// ----------------------------------------------------------------------
	// Clock-run control
	// ----------------------------------------------------------------------

	// Pin inputs come from bus clock domains and pass two flops first.
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			pin_meta <= 3'b000;
			pin_sync <= 3'b000;
		end else begin
			pin_meta <= {pri_stop_req, sec_bus_idle, pri_req_pending};
			pin_sync <= pin_meta;
		end
	end

	// Stop condition depends on the mode bit: a primary request, or an idle
	// secondary bus with nothing pending from the primary side.
	always_comb begin
		if (clock_run_control[`CR_MODE_BIT]) begin
			stop_cond = pin_sync[1] && !pin_sync[0];
		end else begin
			stop_cond = pin_sync[2];
		end
		stop_cond = stop_cond && clock_run_control[`CR_SEC_EN_BIT];
	end

	// One settling cycle on each side of a stop so that a request glitch
	// cannot toggle the secondary clock on consecutive edges.
	always_comb begin
		case (state)
			st_run: begin
				next_state = stop_cond ? st_halt_pend : st_run;
			end
			st_halt_pend: begin
				next_state = stop_cond ? st_halted : st_run;
			end
			st_halted: begin
				next_state = stop_cond ? st_halted : st_wake;
			end
			st_wake: begin
				next_state = st_run;
			end
			default: begin
				next_state = st_run;
			end
		endcase
	end

	// State register of the clock-run sequencer.
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			state <= st_run;
		end else begin
			state <= next_state;
		end
	end

	assign sec_stopped = (state == st_halted);

	// Clock-run outputs, each from its own flop.
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			sec_clk_stop <= 1'b0;
			pri_clk_stop_ok <= 1'b0;
			pri_clock_run_control_on <= 1'b0;
			sec_clock_run_control_on <= 1'b0;
		end else begin
			sec_clk_stop <= (next_state == st_halted);
			pri_clk_stop_ok <= (next_state == st_halted)
				&& clock_run_control[`CR_PRI_EN_BIT]
				&& !clock_run_control[`CR_KEEP_PRI_BIT];
			pri_clock_run_control_on <= clock_run_control[`CR_PRI_EN_BIT];
			sec_clock_run_control_on <= clock_run_control[`CR_SEC_EN_BIT];
		end
	end

	// ----------------------------------------------------------------------
	// Link domain: retry matching and forwarding
	// ----------------------------------------------------------------------

	// A changed option word is parked in opt_hold and announced by toggling
	// opt_req. The hold register only moves again once the link side has echoed
	// the toggle, so the link never captures a word whose bits are in motion.
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			opt_hold <= `PO_RESET;
			opt_req <= 1'b0;
		end else if ((opt_req == ack_sync[1]) && (opt_hold != port_option_control)) begin
			opt_hold <= port_option_control;
			opt_req <= ~opt_req;
		end
	end

	// Echo of the link side's acknowledge toggle, two flops deep.
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			ack_sync <= 2'b00;
		end else begin
			ack_sync <= {ack_sync[0], req_seen};
		end
	end

	// Request toggle brought into the link domain, two flops deep.
	always_ff @(posedge link_clk or negedge rst_b) begin
		if (!rst_b) begin
			req_meta <= 1'b0;
			req_sync <= 1'b0;
		end else begin
			req_meta <= opt_req;
			req_sync <= req_meta;
		end
	end

	// A fresh toggle means opt_hold has stood still for at least a link period,
	// so all its bits are taken together. The price is a few link cycles of
	// latency before a new option word applies to requests.
	always_ff @(posedge link_clk or negedge rst_b) begin
		if (!rst_b) begin
			req_seen <= 1'b0;
			link_opt <= `PO_RESET;
		end else if (req_sync != req_seen) begin
			req_seen <= req_sync;
			link_opt <= opt_hold;
		end
	end

	// Retry comparison answers one link cycle after the request.
	always_ff @(posedge link_clk or negedge rst_b) begin
		if (!rst_b) begin
			retry_done <= 1'b0;
			retry_match <= 1'b0;
		end else begin
			retry_done <= retry_valid;
			if (retry_valid) begin
				retry_match <= alias_match(retry_secondary, retry_cmd, queued_cmd, link_opt);
			end
		end
	end

	// Forwarded command answers one link cycle after the request.
	always_ff @(posedge link_clk or negedge rst_b) begin
		if (!rst_b) begin
			fwd_done <= 1'b0;
			fwd_cmd_out <= 4'h0;
		end else begin
			fwd_done <= fwd_valid;
			if (fwd_valid) begin
				fwd_cmd_out <= forward_cmd(fwd_secondary, fwd_cmd_in, link_opt);
			end
		end
	end

endmodule

// ==== src/bridge_clock_run_control_map.svh ====
/*
 * Register map of the clock-run and retry-alias register bank: byte offsets,
 * bit positions, reset values and write masks.
 * Assumes it is included by bare name, after the type package is compiled.
 */
`ifndef BRIDGE_CLOCK_RUN_CONTROL_MAP_SVH
`define BRIDGE_CLOCK_RUN_CONTROL_MAP_SVH

// --------------------------------------------------------------------------
// Offsets
// --------------------------------------------------------------------------
`define CLOCK_RUN_CONTROL_OFS 8'h6c
`define PORT_OPTION_CONTROL_OFS 8'h74

// --------------------------------------------------------------------------
// Clock-run control fields
// --------------------------------------------------------------------------
`define CR_SEC_STOPPED_BIT 24
`define CR_SEC_EN_BIT 25
`define CR_KEEP_PRI_BIT 26
`define CR_PRI_EN_BIT 27
`define CR_MODE_BIT 28
`define CR_RESET 32'h0000_0000
`define CR_WMASK 32'h1e00_0000

// --------------------------------------------------------------------------
// Port option fields
// --------------------------------------------------------------------------
`define PO_PRI_RD_ALIAS_BIT 1
`define PO_PRI_WR_ALIAS_BIT 2
`define PO_SEC_RD_ALIAS_BIT 3
`define PO_SEC_WR_ALIAS_BIT 4
`define PO_PRI_LM_ALIAS_BIT 5
`define PO_SEC_LM_ALIAS_BIT 6
`define PO_PRI_KEEP_MWI_BIT 7
`define PO_SEC_KEEP_MWI_BIT 8
`define PO_RESET 16'h006a
`define PO_WMASK 16'h01fe

`endif

// ==== src/bridge_clock_run_control_pkg.sv ====
/*
 * Types shared by the clock-run and retry-alias register bank.
 * Assumes nothing of its surroundings.
 */
package bridge_clock_run_control_pkg;

	// Bus command encodings of the memory commands that aliasing touches.
	typedef enum logic [3:0] {
		mem_read_cmd = 4'h6,
		mem_write_cmd = 4'h7,
		mem_read_multiple_cmd = 4'hc,
		mem_read_line_cmd = 4'he,
		mem_write_invalidate_cmd = 4'hf
	} pci_cmd_e;

	// Clock-run states, Gray coded around the loop.
	typedef enum logic [1:0] {
		st_run = 2'b00,
		st_halt_pend = 2'b01,
		st_halted = 2'b11,
		st_wake = 2'b10
	} clock_run_control_state_e;

	typedef logic [3:0] cmd_t;
	typedef logic [15:0] port_opt_t;

endpackage

// ==== sim/bridge_clock_run_control_properties.sv ====
/* Concurrent checks on the clock-run and retry-alias bank ports.
   Assumes it is bound onto the bank, whose link logic runs on link_clk. */
`timescale 1ns/1ps
module bridge_clock_run_control_checker
	import bridge_clock_run_control_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic pri_stop_req,
	input wire logic sec_bus_idle,
	input wire logic pri_req_pending,
	input wire logic sec_clk_stop,
	input wire logic pri_clk_stop_ok,
	input wire logic sec_clock_run_control_on,
	input wire logic link_clk,
	input wire logic retry_valid,
	input wire logic [3:0] retry_cmd,
	input wire logic [3:0] queued_cmd,
	input wire logic retry_done,
	input wire logic retry_match,
	input wire logic fwd_valid,
	input wire logic [3:0] fwd_cmd_in,
	input wire logic [3:0] fwd_cmd_out
);
	// --------------------------------------------------------------------
	// Properties
	// --------------------------------------------------------------------
	// The stop cause is looked for three edges back, past the pin synchroniser.
	property p_okay; @(posedge ref_clk) disable iff (!rst_b) hreadyout && !hresp; endproperty
	property p_stop_en; @(posedge ref_clk) disable iff (!rst_b) $rose(sec_clk_stop) |-> sec_clock_run_control_on; endproperty
	property p_pri_ok; @(posedge ref_clk) disable iff (!rst_b) pri_clk_stop_ok |-> sec_clk_stop; endproperty
	property p_cause; @(posedge ref_clk) disable iff (!rst_b) $rose(sec_clk_stop) |->
		$past(pri_stop_req, 3) || ($past(sec_bus_idle, 3) && !$past(pri_req_pending, 3)); endproperty
	property p_done; @(posedge link_clk) disable iff (!rst_b) retry_valid |=> retry_done; endproperty
	property p_hold; @(posedge link_clk) disable iff (!rst_b) !retry_done |-> $stable(retry_match); endproperty
	property p_exact; @(posedge link_clk) disable iff (!rst_b) retry_valid && retry_cmd == queued_cmd |=> retry_match;
	endproperty
	property p_wr; @(posedge link_clk) disable iff (!rst_b)
		retry_valid && retry_cmd == mem_write_cmd && queued_cmd != mem_write_cmd |=> !retry_match; endproperty
	property p_fwd; @(posedge link_clk) disable iff (!rst_b)
		fwd_valid && fwd_cmd_in != mem_write_invalidate_cmd |=> fwd_cmd_out == $past(fwd_cmd_in); endproperty
	a_okay: assert property (p_okay) else $error("bus answer not ready or not okay");
	a_stop_en: assert property (p_stop_en) else $error("clock stopped while disabled");
	a_pri_ok: assert property (p_pri_ok) else $error("primary stop allowed while running");
	a_cause: assert property (p_cause) else $error("clock stopped without cause");
	a_done: assert property (p_done) else $error("retry answer missing");
	a_hold: assert property (p_hold) else $error("match changed without answer");
	a_exact: assert property (p_exact) else $error("equal commands not matched");
	a_wr: assert property (p_wr) else $error("plain write matched other command");
	a_fwd: assert property (p_fwd) else $error("command altered in forward");
	c_stop: cover property (@(posedge ref_clk) $rose(sec_clk_stop));
	c_match: cover property (@(posedge link_clk) retry_done && retry_match);
	c_conv: cover property (@(posedge link_clk) retry_done && fwd_cmd_out == mem_write_cmd);
endmodule
bind bridge_clock_run_control_and_retry_alias_regs bridge_clock_run_control_checker bridge_clock_run_control_checker_inst (.*);

// ==== sim/link_initiator.sv ====
/* Link-side initiator model issuing retry compares and forward requests.
   Assumes a free-running link clock shared with the bank. */
`timescale 1ns/1ps
module link_initiator
	import bridge_clock_run_control_pkg::*;
(
	input wire logic link_clk,
	output logic retry_valid = 1'b0,
	output logic retry_secondary = 1'b0,
	output cmd_t retry_cmd = 4'h0,
	output cmd_t queued_cmd = 4'h0,
	output logic fwd_valid = 1'b0,
	output logic fwd_secondary = 1'b0,
	output cmd_t fwd_cmd_in = 4'h0
);
	// --------------------------------------------------------------------
	// Request driver
	// --------------------------------------------------------------------
	// Commands are inverted after the pulse so a stale value never looks live.
	task automatic send(input logic s, input cmd_t r, input cmd_t q);
		@(posedge link_clk);
		retry_valid <= 1'b1;
		fwd_valid <= 1'b1;
		retry_secondary <= s;
		fwd_secondary <= s;
		retry_cmd <= r;
		queued_cmd <= q;
		fwd_cmd_in <= r;
		@(posedge link_clk);
		retry_valid <= 1'b0;
		fwd_valid <= 1'b0;
		retry_cmd <= ~r;
		queued_cmd <= ~q;
		fwd_cmd_in <= ~r;
	endtask
endmodule

// ==== sim/tb_bridge_clock_run_control_and_retry_alias_regs.sv ====
/* Self-checking bench of the clock-run and retry-alias bank.
   Assumes the bank, its package and the link initiator model. */
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin failures++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module tb_bridge_clock_run_control_and_retry_alias_regs;
	import bridge_clock_run_control_pkg::*;
	// --------------------------------------------------------------------
	// Signals
	// --------------------------------------------------------------------
	logic ref_clk = 0, link_clk = 0, rst_b = 0, hsel = 0, hwrite = 0, pend_rd = 0;
	logic pri_stop_req = 0, sec_bus_idle = 0, pri_req_pending = 0;
	logic [7:0] haddr = 8'h00;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	wire hreadyout, hresp, sec_clk_stop, pri_clk_stop_ok, pri_clock_run_control_on, sec_clock_run_control_on, retry_done, retry_match;
	wire fwd_done, retry_valid, retry_secondary, fwd_valid, fwd_secondary;
	wire [31:0] hrdata;
	wire [3:0] fwd_cmd_out, retry_cmd, queued_cmd, fwd_cmd_in;
	int failures = 0, samples_checked = 0, cycles = 0;
	logic [31:0] rq[$];
	logic mq[$];
	cmd_t fq[$];
	port_opt_t po;
	logic [31:0] exp_rd;
	logic exp_m;
	cmd_t exp_f;
	cmd_t cmds [5] = '{mem_read_cmd, mem_write_cmd, mem_read_multiple_cmd, mem_read_line_cmd, mem_write_invalidate_cmd};
	bridge_clock_run_control_and_retry_alias_regs bridge_clock_run_control_and_retry_alias_regs_inst (.hready(hreadyout), .*);
	link_initiator link_initiator_inst (.*);
	initial forever #4 ref_clk = ~ref_clk;
	// The link clock is offset so its edges never meet the register clock's.
	initial begin
		#1;
		forever #16 link_clk = ~link_clk;
	end
	// --------------------------------------------------------------------
	// Tasks
	// --------------------------------------------------------------------
	task automatic end_sim;
		if (failures == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		hsel <= 1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= wr;
		@(posedge ref_clk iff hreadyout === 1'b1);
		hsel <= 0;
		htrans <= 2'h0;
		hwdata <= d;
		pend_rd <= !wr;
		@(posedge ref_clk iff hreadyout === 1'b1);
		pend_rd <= 0;
		hwdata <= ~d;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		rq.push_back(e);
		ahb(0, a, 32'h0);
	endtask
	// Expected match and forward result, worked out from the option bits.
	task automatic send(input logic s, input cmd_t r, input cmd_t q);
		mq.push_back(r == q || (po[s ? 3 : 1] && q == mem_read_cmd && (r == 4'hc || r == 4'he))
			|| (po[s ? 4 : 2] && q == mem_write_cmd && r == mem_write_invalidate_cmd)
			|| (po[s ? 6 : 5] && ((r == 4'hc && q == 4'he) || (r == 4'he && q == 4'hc))));
		fq.push_back((r == mem_write_invalidate_cmd && !po[s ? 8 : 7]) ? cmd_t'(mem_write_cmd) : r);
		link_initiator_inst.send(s, r, q);
	endtask
	// --------------------------------------------------------------------
	// Monitors and timeout
	// --------------------------------------------------------------------
	// Each note is popped once before the compare, so a mismatch report cannot eat a second one.
	always @(posedge ref_clk) begin
		if (pend_rd && hreadyout === 1'b1) begin
			exp_rd = rq.pop_front();
			`CHK(hrdata, exp_rd)
		end
	end
	always @(posedge link_clk) begin
		if (retry_done === 1'b1) begin
			exp_m = mq.pop_front();
			`CHK(retry_match, exp_m)
		end
		if (fwd_done === 1'b1) begin
			exp_f = fq.pop_front();
			`CHK(fwd_cmd_out, exp_f)
		end
	end
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			end_sim();
		end
	end
	// --------------------------------------------------------------------
	// Main sequence
	// --------------------------------------------------------------------
	initial begin
		void'($urandom(13191));
		repeat (6) @(posedge ref_clk);
		rst_b <= 1;
		rd(8'h6c, 32'h0);
		rd(8'h74, 32'h6a);
		rd(8'h10, 32'h0);
		ahb(1, 8'h6c, '1);
		rd(8'h6c, 32'h1e00_0000);
		ahb(1, 8'h74, '1);
		rd(8'h74, 32'h1fe);
		for (int k = 0; k < 4; k++) begin
			po = (k == 0) ? 16'h6a : (k == 1) ? 16'h1fe : (k == 2) ? 16'h0 : 16'($urandom) & 16'h1fe;
			ahb(1, 8'h74, {16'h0, po});
			// The option word crosses by a toggle handshake, which may still be busy with the last write.
			repeat (8) @(posedge link_clk);
			for (int i = 0; i < 50; i++) send(1'(i / 25), cmds[i % 5], cmds[(i / 5) % 5]);
		end
		// A one-cycle stop request must not stop the clock; a held one must.
		ahb(1, 8'h6c, 32'h0200_0000);
		pri_stop_req <= 1;
		@(posedge ref_clk) pri_stop_req <= 0;
		repeat (10) @(posedge ref_clk);
		rd(8'h6c, 32'h0200_0000);
		pri_stop_req <= 1;
		repeat (10) @(posedge ref_clk);
		rd(8'h6c, 32'h0300_0000);
		`CHK(pri_clk_stop_ok, 1'b0)
		pri_stop_req <= 0;
		ahb(1, 8'h6c, 32'h1a00_0000);
		sec_bus_idle <= 1;
		repeat (10) @(posedge ref_clk);
		rd(8'h6c, 32'h1b00_0000);
		`CHK({pri_clk_stop_ok, pri_clock_run_control_on, sec_clock_run_control_on}, 3'b111)
		pri_req_pending <= 1;
		repeat (10) @(posedge ref_clk);
		rd(8'h6c, 32'h1a00_0000);
		pri_req_pending <= 0;
		ahb(1, 8'h6c, 32'h1e00_0000);
		repeat (10) @(posedge ref_clk);
		`CHK({pri_clk_stop_ok, sec_clk_stop}, 2'b01)
		rd(8'h6c, 32'h1f00_0000);
		// Every noted result must have been answered; a silent block would otherwise pass.
		repeat (4) @(posedge link_clk);
		`CHK(rq.size() + mq.size() + fq.size(), 0)
		end_sim();
	end
endmodule
